/* File: ppr_pkg.sv */
// Purpose: shared constants and carriers for the parallel port register bank
// Assumes: 8-bit ISA host data, offsets relative to the port base address
// Notes: offsets are byte offsets from the base
package ppr_pkg;
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 16;
   localparam int          FIFO_DEPTH    = 16;
   localparam logic [10:0] OFF_DATA      = 11'h000;
   localparam logic [10:0] OFF_STATUS    = 11'h001;
   localparam logic [10:0] OFF_CONTROL   = 11'h002;
   localparam logic [10:0] OFF_FIFO      = 11'h400;
   localparam logic [10:0] OFF_CAP_B     = 11'h401;
   localparam logic [10:0] OFF_ECR       = 11'h402;
   localparam logic [7:0]  CAP_A_VALUE   = 8'h10;
   localparam logic [7:0]  DATA_RESET    = 8'h00;
   localparam logic [5:0]  CTRL_RESET    = 6'h00;
   localparam logic [2:0]  ECR_RESET_MODE = 3'h0;
   localparam logic [4:0]  WR_LEVEL_DEF  = 5'h08;
   localparam logic [4:0]  RD_LEVEL_DEF  = 5'h08;
   localparam int          B_STROBE      = 0;
   localparam int          B_LINEFEED    = 1;
   localparam int          B_INIT        = 2;
   localparam int          B_SELECT      = 3;
   localparam int          B_ACKIRQ      = 4;
   localparam int          B_DIR         = 5;
   localparam int          B_FAULT       = 3;
   localparam int          B_ONLINE      = 4;
   localparam int          B_PERR        = 5;
   localparam int          B_ACK         = 6;
   localparam int          B_BUSY        = 7;
   localparam int          B_IRQLVL      = 6;
   localparam int          B_SVC         = 2;
   localparam int          B_FULL        = 1;
   localparam int          B_EMPTY       = 0;

   typedef enum logic [2:0]
   {
      MODE_COMPAT    = 3'h0,
      MODE_BIDIR     = 3'h1,
      MODE_COMPAT_FIFO_PORT     = 3'h2,
      MODE_STREAM    = 3'h3,
      MODE_EPP       = 3'h4,
      MODE_RSVD      = 3'h5,
      MODE_TEST      = 3'h6,
      MODE_CONFIG    = 3'h7
   } ppr_mode_type;

   typedef struct packed
   {
      logic       tag;
      logic [7:0] data;
   } ppr_fifo_word_type;

   typedef struct packed
   {
      logic fault;
      logic online;
      logic perr;
      logic ack;
      logic busy;
   } ppr_status_type;
endpackage

/* File: ppr_fifo.sv */
// Purpose: parameterised fifo with valid/ready on both sides
// Assumes: single clock
// Notes: count width holds depth inclusive
module ppr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire logic                     flush,
   // fill side
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [WIDTH-1:0]         in_data,
   // drain side
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic      [WIDTH-1:0]         out_data,
   // state
   output logic      [$clog2(DEPTH):0]   count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rp_r];
   assign count     = cnt_r;

   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wp_r] <= in_data;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else if (flush)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wp_r <= wp_r + AW'(1);
         if (pop)
            rp_r <= rp_r + AW'(1);
         if (push && !pop)
            cnt_r <= cnt_r + (AW+1)'(1);
         else if (pop && !push)
            cnt_r <= cnt_r - (AW+1)'(1);
      end
   end
endmodule

/* File: ppr_regs.sv */
// Purpose: host register bank of a multi-mode parallel port
// Assumes: isa strobes and port pins are asynchronous and synchronised here
// Notes: peripheral handshakes are reduced to a one-byte-per-strobe drain
module ppr_regs (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // isa host side
   input  wire logic [15:0]           isa_addr,
   input  wire logic                  isa_aen,
   input  wire logic                  io_write_strobe_n,
   input  wire logic                  io_read_strobe_n,
   input  wire logic [7:0]            isa_data_in,
   output logic      [7:0]            isa_data_out,
   output logic                       isa_data_oe,
   output logic                       irq_out,
   // configuration
   input  wire logic [15:0]           port_base,
   input  wire logic                  epp_enable,
   // port data lines
   input  wire logic [7:0]            port_data_lines_in,
   output logic      [7:0]            port_data_lines_out,
   output logic                       port_data_lines_oe,
   // port control outputs
   output logic                       data_strobe_out,
   output logic                       line_feed_out,
   output logic                       port_initialise_out,
   output logic                       peripheral_select_out,
   // port status inputs
   input  wire logic                  fault_input,
   input  wire logic                  online_input,
   input  wire logic                  paper_error_input,
   input  wire logic                  ack_input,
   input  wire logic                  busy_input
);
   localparam int FW = 9;
   logic [1:0]  wr_s_r;
   logic [1:0]  rd_s_r;
   logic [1:0]  aen_s_r;
   logic [7:0]  pd_s1_r;
   logic [7:0]  pd_s2_r;
   logic [4:0]  st_s1_r;
   logic [4:0]  st_s2_r;
   logic        ack_d_r;
   logic        wr_d_r;
   logic        rd_d_r;
   logic [7:0]  data_latch_r;
   logic [5:0]  ctrl_r;
   logic [2:0]  mode_r;
   logic        svc_r;
   logic        svc_nxt;
   logic        irq_r;
   logic [7:0]  last_r;
   logic [7:0]  rdata_r;
   logic [4:0]  wr_level_r;
   logic [4:0]  rd_level_r;
   logic        busy_drain_r;
   logic        wr_evt;
   logic        rd_evt;
   logic        hit;
   logic [10:0] off;
   logic        dir_in;
   logic        fifo_mode;
   logic        f_in_valid;
   logic        f_in_ready;
   logic        f_out_valid;
   logic        f_out_ready;
   logic [$clog2(ppr_pkg::FIFO_DEPTH):0] f_count;
   ppr_pkg::ppr_fifo_word_type f_in;
   ppr_pkg::ppr_fifo_word_type f_out;
   ppr_pkg::ppr_status_type    st;
   ppr_pkg::ppr_mode_type      mode;

   function automatic logic sel(input logic [10:0] o, input logic [10:0] want);
      sel = (o == want);
   endfunction

   assign mode = ppr_pkg::ppr_mode_type'(mode_r);
   assign st   = ppr_pkg::ppr_status_type'(st_s2_r);
   assign off  = 11'(isa_addr - port_base);
   assign hit  = !aen_s_r[1] && (isa_addr >= port_base) && (isa_addr - port_base <= 16'(ppr_pkg::OFF_ECR));
   assign wr_evt = hit && wr_s_r[1] && !wr_d_r;
   assign rd_evt = hit && !rd_s_r[1] && rd_d_r;
   assign dir_in = ctrl_r[ppr_pkg::B_DIR] && (mode != ppr_pkg::MODE_COMPAT) && (mode != ppr_pkg::MODE_COMPAT_FIFO_PORT);
   assign fifo_mode = (mode == ppr_pkg::MODE_COMPAT_FIFO_PORT) || (mode == ppr_pkg::MODE_STREAM) || (mode == ppr_pkg::MODE_TEST);

   // synchronisers: first stage read only by second
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_s_r  <= 2'h3;
         rd_s_r  <= 2'h3;
         aen_s_r <= 2'h3;
         pd_s1_r <= 8'h00;
         pd_s2_r <= 8'h00;
         st_s1_r <= 5'h00;
         st_s2_r <= 5'h00;
         wr_d_r  <= 1'b1;
         rd_d_r  <= 1'b1;
         ack_d_r <= 1'b0;
      end
      else
      begin
         wr_s_r  <= {wr_s_r[0], io_write_strobe_n};
         rd_s_r  <= {rd_s_r[0], io_read_strobe_n};
         aen_s_r <= {aen_s_r[0], isa_aen};
         pd_s1_r <= port_data_lines_in;
         pd_s2_r <= pd_s1_r;
         st_s1_r <= {fault_input, online_input, paper_error_input, ack_input, busy_input};
         st_s2_r <= st_s1_r;
         wr_d_r  <= wr_s_r[1];
         rd_d_r  <= rd_s_r[1];
         ack_d_r <= st.ack;
      end
   end

   // data latch
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         data_latch_r <= ppr_pkg::DATA_RESET;
      else if (wr_evt && sel(off, ppr_pkg::OFF_DATA) &&
               (mode == ppr_pkg::MODE_COMPAT || mode == ppr_pkg::MODE_BIDIR))
         data_latch_r <= isa_data_in;
   end

   // control and extended control; modes other than 000/001 are left only back to 000/001
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= ppr_pkg::CTRL_RESET;
         mode_r <= ppr_pkg::ECR_RESET_MODE;
      end
      else if (wr_evt)
      begin
         if (sel(off, ppr_pkg::OFF_CONTROL))
            ctrl_r <= isa_data_in[5:0];
         if (sel(off, ppr_pkg::OFF_ECR) &&
             (mode_r[2:1] == 2'h0 || isa_data_in[7:6] == 2'h0) &&
             !(isa_data_in[7:5] == 3'h4 && !epp_enable))
            mode_r <= isa_data_in[7:5];
      end
   end

   // thresholds fixed at half depth; software finds them in test mode
   assign wr_level_r = ppr_pkg::WR_LEVEL_DEF;
   assign rd_level_r = ppr_pkg::RD_LEVEL_DEF;

   // service flag: hardware set wins over a software clear
   always_comb
   begin
      svc_nxt = svc_r;
      if (wr_evt && sel(off, ppr_pkg::OFF_ECR))
         svc_nxt = isa_data_in[ppr_pkg::B_SVC];
      if (fifo_mode && !svc_r &&
          ((!dir_in && (5'(ppr_pkg::FIFO_DEPTH) - 5'(f_count)) >= wr_level_r) ||
           (dir_in && 5'(f_count) >= rd_level_r)))
         svc_nxt = 1'b1;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         svc_r <= 1'b1;
      else
         svc_r <= svc_nxt;
   end

   // acknowledge interrupt
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         irq_r <= 1'b0;
      else
         irq_r <= ctrl_r[ppr_pkg::B_ACKIRQ] && st.ack && !ack_d_r;
   end
   assign irq_out = irq_r;

   // fifo fill: host writes forward, port bytes in reverse stream mode
   always_comb
   begin
      f_in_valid = 1'b0;
      f_in.tag   = 1'b0;
      f_in.data  = isa_data_in;
      if (wr_evt && sel(off, ppr_pkg::OFF_FIFO) && fifo_mode &&
          (mode == ppr_pkg::MODE_TEST || !dir_in))
         f_in_valid = 1'b1;
      else if (wr_evt && sel(off, ppr_pkg::OFF_DATA) && mode == ppr_pkg::MODE_STREAM && !dir_in)
      begin
         f_in_valid = 1'b1;
         f_in.tag   = 1'b1;
      end
      else if (mode == ppr_pkg::MODE_STREAM && dir_in && st.ack && !ack_d_r)
      begin
         f_in_valid = 1'b1;
         f_in.data  = pd_s2_r;
      end
   end

   // fifo drain: one byte per free peripheral in forward modes, host reads otherwise
   always_comb
   begin
      f_out_ready = 1'b0;
      if ((mode == ppr_pkg::MODE_COMPAT_FIFO_PORT || (mode == ppr_pkg::MODE_STREAM && !dir_in)) &&
          !st.busy && !busy_drain_r)
         f_out_ready = 1'b1;
      else if (rd_evt && sel(off, ppr_pkg::OFF_FIFO) &&
               (mode == ppr_pkg::MODE_TEST || (mode == ppr_pkg::MODE_STREAM && dir_in)))
         f_out_ready = 1'b1;
   end

   // full writes are dropped by the fifo itself, so test mode never waits
   ppr_fifo #(
      .WIDTH (FW),
      .DEPTH (ppr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .flush     (mode == ppr_pkg::MODE_COMPAT || mode == ppr_pkg::MODE_BIDIR),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out),
      .count     (f_count)
   );

   // last byte seen and one-shot strobe per drained byte
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         last_r       <= 8'h00;
         busy_drain_r <= 1'b0;
      end
      else
      begin
         if (f_out_valid && f_out_ready)
            last_r <= f_out.data;
         busy_drain_r <= (f_out_valid && f_out_ready && mode != ppr_pkg::MODE_TEST) ||
                         (busy_drain_r && !st.busy && fifo_mode);
      end
   end

   // read mux
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rdata_r <= 8'h00;
      else if (hit && !rd_s_r[1])
      begin
         rdata_r <= 8'h00;
         if (sel(off, ppr_pkg::OFF_DATA) && (mode == ppr_pkg::MODE_COMPAT || mode == ppr_pkg::MODE_BIDIR))
            rdata_r <= pd_s2_r;
         else if (sel(off, ppr_pkg::OFF_STATUS))
            rdata_r <= {!st.busy, st.ack, st.perr, st.online, st.fault, 3'h0};
         else if (sel(off, ppr_pkg::OFF_CONTROL))
            rdata_r <= {2'h0, ctrl_r};
         else if (sel(off, ppr_pkg::OFF_ECR))
            rdata_r <= {mode_r, 2'h0, svc_r, !f_in_ready, !f_out_valid};
         else if (sel(off, ppr_pkg::OFF_FIFO) && mode == ppr_pkg::MODE_CONFIG)
            rdata_r <= ppr_pkg::CAP_A_VALUE;
         else if (sel(off, ppr_pkg::OFF_CAP_B) && mode == ppr_pkg::MODE_CONFIG)
            rdata_r <= {1'b0, irq_r, 6'h00};
         else if (sel(off, ppr_pkg::OFF_FIFO) &&
                  (mode == ppr_pkg::MODE_TEST || (mode == ppr_pkg::MODE_STREAM && dir_in)))
         begin
            // the pop happens on the first cycle only, so the popped byte must stand for the rest
            if (rd_d_r)
               rdata_r <= f_out_valid ? f_out.data : last_r;
            else
               rdata_r <= rdata_r;
         end
      end
   end
   assign isa_data_out = rdata_r;
   assign isa_data_oe  = hit && !rd_s_r[1];

   // pins
   assign port_data_lines_out   = (mode == ppr_pkg::MODE_TEST || fifo_mode) ?
                                  (f_out_valid ? f_out.data : last_r) : data_latch_r;
   assign port_data_lines_oe    = !dir_in;
   assign data_strobe_out       = !(ctrl_r[ppr_pkg::B_STROBE] || (busy_drain_r && mode != ppr_pkg::MODE_TEST));
   assign line_feed_out         = !ctrl_r[ppr_pkg::B_LINEFEED];
   assign port_initialise_out   = ctrl_r[ppr_pkg::B_INIT];
   assign peripheral_select_out = !ctrl_r[ppr_pkg::B_SELECT];
endmodule

/* File: ppr_regs_properties.sv */
// Purpose: concurrent checks on the parallel port register bank ports
// Assumes: host strobes stay low and high for six clocks each
// Notes: mode and write data are shadowed from the host bus here
module ppr_regs_chk (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // host side
   input wire logic [15:0] isa_addr,
   input wire logic        isa_aen,
   input wire logic        io_write_strobe_n,
   input wire logic        io_read_strobe_n,
   input wire logic [7:0]  isa_data_in,
   input wire logic [7:0]  isa_data_out,
   input wire logic        isa_data_oe,
   input wire logic        irq_out,
   input wire logic [15:0] port_base,
   // port pins
   input wire logic [7:0]  port_data_lines_out,
   input wire logic        port_data_lines_oe,
   input wire logic        data_strobe_out,
   input wire logic        line_feed_out,
   input wire logic        port_initialise_out,
   input wire logic        peripheral_select_out,
   input wire logic        fault_input,
   input wire logic        online_input,
   input wire logic        paper_error_input,
   input wire logic        ack_input,
   input wire logic        busy_input
);
   logic       wq_r;
   logic [7:0] wd_r;
   logic [2:0] mode_r;
   logic       wr_rise;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   function automatic logic hit(input logic [10:0] off);
      return !isa_aen && ((isa_addr - port_base) == {5'h00, off});
   endfunction

   assign wr_rise = io_write_strobe_n && !wq_r;

   // shadow of the last host write; mode taken early, the design lags by the sync
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wq_r   <= 1'b1;
         wd_r   <= 8'h00;
         mode_r <= 3'h0;
      end
      else
      begin
         wq_r <= io_write_strobe_n;
         if (wr_rise)
            wd_r <= isa_data_in;
         if (wr_rise && hit(ppr_pkg::OFF_ECR))
            mode_r <= isa_data_in[7:5];
      end
   end

   sequence rd_held(logic [10:0] off);
      (!io_read_strobe_n && hit(off))[*6];
   endsequence

   sequence ctl_wr;
      wr_rise && hit(ppr_pkg::OFF_CONTROL);
   endsequence

   ctl_pins_a:
      assert property (ctl_wr |-> ##6 (data_strobe_out == !wd_r[0] && line_feed_out == !wd_r[1]
         && port_initialise_out == wd_r[2] && peripheral_select_out == !wd_r[3]))
      else $error("control pins differ from written bits");
   data_pins_a:
      assert property (wr_rise && hit(ppr_pkg::OFF_DATA) && mode_r[2:1] == 2'h0
         |-> ##6 port_data_lines_out == wd_r)
      else $error("data latch not on port lines");
   read_oe_a:
      assert property (isa_data_oe |-> !$past(io_read_strobe_n, 2) && !$past(isa_aen, 2))
      else $error("read data driven without qualified read");
   irq_pulse_a:
      assert property (irq_out |=> !irq_out)
      else $error("interrupt longer than one cycle");
   irq_cause_a:
      assert property (irq_out |-> $past(ack_input, 2) && !$past(ack_input, 8))
      else $error("interrupt without acknowledge rise");
   dir_out_a:
      assert property (wr_rise && hit(ppr_pkg::OFF_ECR) && !isa_data_in[7] && !isa_data_in[5]
         |-> ##6 port_data_lines_oe)
      else $error("port not driven in output-only mode");
   status_read_a:
      assert property (rd_held(ppr_pkg::OFF_STATUS) |-> isa_data_out == {!busy_input, ack_input,
         paper_error_input, online_input, fault_input, 3'h0})
      else $error("status read wrong");
   ctl_read_a:
      assert property (rd_held(ppr_pkg::OFF_CONTROL) |-> isa_data_out[7:6] == 2'h0)
      else $error("control upper bits not zero");
   cap_a_a:
      assert property (rd_held(ppr_pkg::OFF_FIFO) ##0 (mode_r == 3'h7) |-> isa_data_out == ppr_pkg::CAP_A_VALUE)
      else $error("capability a wrong");
   cap_b_a:
      assert property (rd_held(ppr_pkg::OFF_CAP_B) ##0 (mode_r == 3'h7)
         |-> isa_data_out[7] == 1'b0 && isa_data_out[5:0] == 6'h00)
      else $error("capability b fixed bits wrong");
endmodule

bind ppr_regs ppr_regs_chk u_chk (.ref_clk(ref_clk), .rst(rst), .isa_addr(isa_addr), .isa_aen(isa_aen),
   .io_write_strobe_n(io_write_strobe_n), .io_read_strobe_n(io_read_strobe_n), .isa_data_in(isa_data_in),
   .isa_data_out(isa_data_out), .isa_data_oe(isa_data_oe), .irq_out(irq_out), .port_base(port_base),
   .port_data_lines_out(port_data_lines_out), .port_data_lines_oe(port_data_lines_oe),
   .data_strobe_out(data_strobe_out), .line_feed_out(line_feed_out), .port_initialise_out(port_initialise_out),
   .peripheral_select_out(peripheral_select_out), .fault_input(fault_input), .online_input(online_input),
   .paper_error_input(paper_error_input), .ack_input(ack_input), .busy_input(busy_input));

/* File: ppr_printer_model.sv */
// Purpose: peripheral on the port pins, busy handshake and reverse data
// Assumes: strobe pin is active low
// Notes: BUSY_DLY sets a prompt or slow answer
module ppr_printer_model #(
   parameter int BUSY_DLY = 2
) (
   // clock
   input wire logic        ref_clk,
   // port pins
   input wire logic [7:0]  port_data_lines_out,
   input wire logic        port_data_lines_oe,
   input wire logic        data_strobe_out,
   output logic     [7:0]  port_data_lines_in,
   output logic            busy_input,
   // bench controls
   input wire logic        hold_busy,
   input wire logic        rev_drive,
   input wire logic [7:0]  rev_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_r = 8'h00;
   logic [7:0] sh_r = 8'h00;

   // a released line shows the inverse of its last level, never a stale copy
   assign port_data_lines_in = port_data_lines_oe ? port_data_lines_out : (rev_drive ? rev_byte : ~last_r);
   assign busy_input = hold_busy | sh_r[BUSY_DLY];

   always_ff @(posedge ref_clk)
   begin
      if (port_data_lines_oe || rev_drive)
         last_r <= port_data_lines_in;
      sh_r   <= {sh_r[6:0], !data_strobe_out};
   end
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench for the parallel port register bank
// Assumes: strobes held six clocks per phase, past the sync delay
// Notes: service thresholds and the handshake drains are checked neither here nor by the assertions
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, rst, isa_aen, wr_n, rd_n, irq_out, isa_data_oe, aen_q;
   logic [15:0] isa_addr;
   logic [7:0]  isa_data_in, isa_data_out, pd_in, pd_out, rev_byte;
   logic        pd_oe, stb, lf, ini, sel, fault_in, online_in, perr_in, ack_in, busy;
   logic        hold_busy, rev_drive;
   int          n_fail, n_compared, cyc;
   localparam logic [15:0] BASE = 16'h0278;

   ppr_regs uut (.ref_clk(ref_clk), .rst(rst), .isa_addr(isa_addr), .isa_aen(isa_aen),
      .io_write_strobe_n(wr_n), .io_read_strobe_n(rd_n), .isa_data_in(isa_data_in),
      .isa_data_out(isa_data_out), .isa_data_oe(isa_data_oe), .irq_out(irq_out), .port_base(BASE),
      .epp_enable(1'b0), .port_data_lines_in(pd_in), .port_data_lines_out(pd_out),
      .port_data_lines_oe(pd_oe), .data_strobe_out(stb), .line_feed_out(lf), .port_initialise_out(ini),
      .peripheral_select_out(sel), .fault_input(fault_in), .online_input(online_in),
      .paper_error_input(perr_in), .ack_input(ack_in), .busy_input(busy));

   ppr_printer_model #(.BUSY_DLY(2)) u_prn (.ref_clk(ref_clk), .port_data_lines_out(pd_out),
      .port_data_lines_oe(pd_oe), .data_strobe_out(stb), .port_data_lines_in(pd_in), .busy_input(busy),
      .hold_busy(hold_busy), .rev_drive(rev_drive), .rev_byte(rev_byte));

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // roughly 60 host accesses of 13 clocks each
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc > 4000)
      begin
         n_fail++;
         summarize();
      end
   end

   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // request held until the answer is taken; address kept through the high phase
   task automatic acc(input logic wr, input logic [10:0] off, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge ref_clk);
      isa_addr <= BASE + {5'h00, off};
      isa_aen <= aen_q;
      isa_data_in <= wd;
      if (wr)
         wr_n <= 1'b0;
      else
         rd_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd = isa_data_out;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [10:0] off, input logic [7:0] d);
      logic [7:0] v;
      acc(1'b1, off, d, v);
   endtask

   task automatic rdc(input logic [10:0] off, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
      logic [7:0] v;
      acc(1'b0, off, 8'h00, v);
      chk(v & mask, exp);
   endtask

   task automatic t_reset();
      chk({4'h0, stb, lf, ini, sel}, 8'h0d);
      chk(pd_out, 8'h00);
      rdc(ppr_pkg::OFF_CONTROL, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_data();
      wr(ppr_pkg::OFF_DATA, 8'ha5);
      chk(pd_out, 8'ha5);
      rdc(ppr_pkg::OFF_DATA, 8'ha5);
      aen_q = 1'b1;
      wr(ppr_pkg::OFF_DATA, 8'h5a);
      aen_q = 1'b0;
      chk(pd_out, 8'ha5);
      $display("test data done");
   endtask

   task automatic t_ctrl();
      wr(ppr_pkg::OFF_CONTROL, 8'hff);
      rdc(ppr_pkg::OFF_CONTROL, 8'h3f);
      chk({4'h0, stb, lf, ini, sel}, 8'h02);
      chk({7'h00, pd_oe}, 8'h01);
      wr(ppr_pkg::OFF_ECR, 8'h20);
      chk({7'h00, pd_oe}, 8'h00);
      rev_byte <= 8'h3c;
      rev_drive <= 1'b1;
      rdc(ppr_pkg::OFF_DATA, 8'h3c);
      rev_drive <= 1'b0;
      wr(ppr_pkg::OFF_CONTROL, 8'h00);
      wr(ppr_pkg::OFF_ECR, 8'h00);
      $display("test control done");
   endtask

   task automatic t_status();
      logic [4:0] pats[4] = '{5'h1f, 5'h15, 5'h0a, 5'h00};
      logic [4:0] p;
      for (int i = 0; i < 4; i++)
      begin
         p = pats[i];
         @(posedge ref_clk);
         {fault_in, online_in, perr_in, ack_in, hold_busy} <= p;
         repeat (5) @(posedge ref_clk);
         rdc(ppr_pkg::OFF_STATUS, {!p[0], p[1], p[2], p[3], p[4], 3'h0});
      end
      $display("test status done");
   endtask

   task automatic count_ack(output int n);
      n = 0;
      @(posedge ref_clk);
      ack_in <= 1'b1;
      repeat (20)
      begin
         @(posedge ref_clk);
         n += (irq_out === 1'b1) ? 1 : 0;
      end
      ack_in <= 1'b0;
      repeat (10) @(posedge ref_clk);
   endtask

   task automatic t_irq();
      int n;
      wr(ppr_pkg::OFF_CONTROL, 8'h10);
      count_ack(n);
      chk(n[7:0], 8'h01);
      wr(ppr_pkg::OFF_CONTROL, 8'h00);
      count_ack(n);
      chk(n[7:0], 8'h00);
      $display("test interrupt done");
   endtask

   task automatic t_cfg();
      wr(ppr_pkg::OFF_ECR, 8'he0);
      rdc(ppr_pkg::OFF_FIFO, 8'h10);
      wr(ppr_pkg::OFF_CAP_B, 8'hff);
      rdc(ppr_pkg::OFF_CAP_B, 8'h00);
      wr(ppr_pkg::OFF_ECR, 8'h00);
      rdc(ppr_pkg::OFF_FIFO, 8'h00);
      $display("test capability done");
   endtask

   task automatic t_fifo();
      wr(ppr_pkg::OFF_ECR, 8'hc0);
      for (int i = 0; i < 17; i++)
         wr(ppr_pkg::OFF_FIFO, 8'h40 + 8'(i));
      rdc(ppr_pkg::OFF_ECR, 8'hc2, 8'he3);
      for (int i = 0; i < 16; i++)
         rdc(ppr_pkg::OFF_FIFO, 8'h40 + 8'(i));
      rdc(ppr_pkg::OFF_FIFO, 8'h4f);
      rdc(ppr_pkg::OFF_ECR, 8'hc1, 8'he3);
      wr(ppr_pkg::OFF_ECR, 8'h00);
      $display("test fifo done");
   endtask

   initial
   begin
      {rst, wr_n, rd_n} = 3'h7;
      {isa_aen, aen_q, fault_in, online_in, perr_in, ack_in, hold_busy, rev_drive} = 8'h00;
      {isa_addr, isa_data_in, rev_byte} = 32'h0;
      n_fail = 0;
      n_compared = 0;
      cyc = 0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_data();
      t_ctrl();
      t_status();
      t_irq();
      t_cfg();
      t_fifo();
      summarize();
   end
endmodule
